// File: src/sps_pkg.sv
package sps_pkg;
   // Printed offsets are word indices; byte address is four times
   localparam logic [7:0] IDX_SEL_A = 8'h26;
   localparam logic [7:0] IDX_SEL_B = 8'h27;
   localparam logic [7:0] IDX_SEL_C = 8'h28;
   localparam logic [7:0] IDX_SEL_D = 8'h29;
   localparam logic [7:0] IDX_MASK = 8'h25;
   localparam logic [7:0] IDX_CTRL = 8'h2a;
   localparam logic [7:0] IDX_STAT = 8'h31;
   localparam logic [7:0] IDX_PEND = 8'h2b;
   localparam int ADDR_LSB = 2;
   localparam int FLAG_BIT = 8;
   localparam int MASK_UNUSABLE = 1;
   localparam int MASK_CORRUPT = 3;
   localparam int MASK_NONAUDIO = 4;
   localparam int MASK_BURST = 5;
   localparam logic [8:0] RST_SEL_A = 9'h010;
   localparam logic [8:0] RST_SEL_B = 9'h032;
   localparam logic [8:0] RST_SEL_C = 9'h054;
   localparam logic [8:0] RST_SEL_D = 9'h006;
   localparam logic [8:0] RST_MASK = 9'h000;
   localparam logic [3:0] SRC_IRQ = 4'h0;
   localparam logic [3:0] SRC_VALID = 4'h1;
   localparam logic [3:0] SRC_USER = 4'h2;
   localparam logic [3:0] SRC_CHST = 4'h3;
   localparam logic [3:0] SRC_PAR = 4'h4;
   localparam logic [3:0] SRC_SFRM = 4'h5;
   localparam logic [3:0] SRC_BLK = 4'h6;
   localparam logic [3:0] SRC_UNLOCK = 4'h7;
   localparam logic [3:0] SRC_CHAN_STAT_UPDATED = 4'h8;
   localparam logic [3:0] SRC_UNUSE = 4'h9;
   localparam logic [3:0] SRC_ZERO = 4'ha;
   localparam logic [3:0] SRC_NONPCM = 4'hb;
   localparam logic [3:0] SRC_COPY = 4'hc;
   localparam logic [3:0] SRC_EMPH = 4'hd;
   localparam logic [3:0] SRC_IN_CMOS = 4'he;
   localparam logic [3:0] SRC_IN_CMP = 4'hf;
   localparam int SYNC_BITS = 96;
   // Burst sync pattern over sample MSBs; value is arbitrary
   localparam logic [95:0] SYNC_CODE = 96'h0000_0000_0000_0000_a5c3;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: src/sps_hold_mem.sv
`timescale 1ns/1ps
// Last good sample store, one word per channel, registered read
module sps_hold_mem #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 2
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem_r [DEPTH];

   // Words start at zero so a flagged first sample gives silence
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= '0;
         end
         rd_data <= '0;
      end else begin
         if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
         end
         rd_data <= mem_r[rd_addr];
      end
   end
endmodule

// File: src/sps_err_pins.sv
`timescale 1ns/1ps
// Receiver error handling, non-PCM mute, status pin multiplexer
module sps_err_pins #(
   parameter int WIDTH = 24
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_valid,
   input wire logic [WIDTH-1:0] rx_data,
   input wire logic rx_chan,
   input wire logic rx_corrupt,
   input wire logic rx_vbit,
   input wire logic rx_ubit,
   input wire logic rx_cbit,
   input wire logic rx_pbit,
   input wire logic rx_nonaudio,
   input wire logic rx_blk_start,
   input wire logic rx_unlock,
   input wire logic rx_chan_stat_updated,
   input wire logic rx_zero,
   input wire logic rx_copy_low,
   input wire logic rx_emph,
   input wire logic first_converter_from_rx,
   input wire logic [6:0] pin_in,
   output logic aud_valid,
   output logic [WIDTH-1:0] aud_data,
   output logic aud_chan,
   output logic tx_valid,
   output logic [WIDTH-1:0] tx_data,
   output logic tx_chan,
   output logic first_converter_mute,
   output logic int_b,
   output logic [6:0] status_output_pin,
   output logic [6:0] status_output_pin_oe,
   output logic [2:0] pin_rx_cmos,
   output logic [2:0] pin_rx_cmp
);
   typedef struct packed {
      logic awr;
      logic wr;
      logic bv;
      logic rv;
      logic arr;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [1:0] bresp;
      logic [8:0] sel_a;
      logic [8:0] sel_b;
      logic [8:0] sel_c;
      logic [8:0] sel_d;
      logic [8:0] mask;
      logic [3:0] pend;
      logic corrupt_flag;
      logic unusable_flag;
      logic nonaudio_flag;
      logic burst_flag;
      logic [95:0] shreg;
      logic s1_v;
      logic [WIDTH-1:0] s1_data;
      logic s1_chan;
      logic s1_aud_sub;
      logic s1_tx_sub;
      logic aud_v;
      logic [WIDTH-1:0] aud_d;
      logic aud_c;
      logic tx_v;
      logic [WIDTH-1:0] tx_d;
      logic tx_c;
      logic mute;
      logic irq_b;
      logic [6:0] pin_o;
      logic [6:0] pin_oe;
      logic [2:0] in_cmos;
      logic [2:0] in_cmp;
   } sps_state_s;

   sps_state_s st_r;
   sps_state_s st_nxt;
   logic [6:0] pin_s1_r, pin_s2_r, pin_s3_r;
   logic [6:0] pin_clean_r;
   logic [WIDTH-1:0] hold_word;
   logic [27:0] pin_sel_flat;

   // Pick the status signal named by a four-bit pin code
   function automatic logic pick_src(input logic [3:0] code, input logic irq_lvl,
                                     input logic [13:1] sig);
      logic o;
      o = 1'b0;
      if (code == sps_pkg::SRC_IRQ) begin
         o = irq_lvl;
      end else if (code <= sps_pkg::SRC_EMPH) begin
         o = sig[code];
      end
      return o;
   endfunction

   // Word index from a byte address
   function automatic logic [7:0] word_idx(input logic [31:0] a);
      return a[sps_pkg::ADDR_LSB+7:sps_pkg::ADDR_LSB];
   endfunction

   // Three-stage capture of the pin levels; change taken when stages 2 and 3 agree
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1_r <= 7'h00;
         pin_s2_r <= 7'h00;
         pin_s3_r <= 7'h00;
         pin_clean_r <= 7'h00;
      end else begin
         pin_s1_r <= pin_in;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         for (int i = 0; i < 7; i++) begin
            if (pin_s2_r[i] == pin_s3_r[i]) begin
               pin_clean_r[i] <= pin_s3_r[i];
            end
         end
      end
   end

   // Per-channel last good sample store, read one cycle after the sample
   sps_hold_mem #(.WIDTH(WIDTH), .DEPTH(2)) u_hold (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .wr_en(st_r.s1_v && !st_r.s1_aud_sub),
      .wr_addr(st_r.s1_chan),
      .wr_data(st_r.s1_data),
      .rd_addr(rx_chan),
      .rd_data(hold_word)
   );

   assign pin_sel_flat = {st_r.sel_d[3:0], st_r.sel_c[7:4], st_r.sel_c[3:0],
                          st_r.sel_b[7:4], st_r.sel_b[3:0], st_r.sel_a[7:4],
                          st_r.sel_a[3:0]};

   always_comb begin
      logic [8:0] wv;
      logic [7:0] widx;
      logic [7:0] ridx;
      logic [3:0] ev;
      logic [3:0] en;
      logic unuse_sub;
      logic corr_sub;
      logic [3:0] code;
      logic [13:1] sig;
      wv = '0;
      widx = '0;
      ridx = '0;
      ev = '0;
      en = '0;
      unuse_sub = 1'b0;
      corr_sub = 1'b0;
      code = '0;
      sig = '0;
      st_nxt = st_r;

      // Write channel: ready only once both wait, so address and data still stand when used
      if (s_axi_awvalid && s_axi_wvalid && !st_r.awr && !st_r.wr && !st_r.bv) begin
         st_nxt.awr = 1'b1;
         st_nxt.wr = 1'b1;
      end
      if (st_r.awr && st_r.wr) begin
         widx = word_idx(s_axi_awaddr);
         wv = s_axi_wdata[8:0];
         st_nxt.awr = 1'b0;
         st_nxt.wr = 1'b0;
         st_nxt.bv = 1'b1;
         st_nxt.bresp = sps_pkg::RESP_OKAY;
         if (s_axi_wstrb[0] && s_axi_wstrb[1]) begin
            case (widx)
               sps_pkg::IDX_SEL_A: st_nxt.sel_a = wv;
               sps_pkg::IDX_SEL_B: st_nxt.sel_b = wv;
               sps_pkg::IDX_SEL_C: st_nxt.sel_c = wv;
               sps_pkg::IDX_SEL_D: st_nxt.sel_d = wv;
               sps_pkg::IDX_MASK: st_nxt.mask = wv;
               sps_pkg::IDX_PEND: st_nxt.pend = st_r.pend & ~wv[3:0];
               sps_pkg::IDX_STAT, sps_pkg::IDX_CTRL: st_nxt.bresp = sps_pkg::RESP_OKAY;
               default: st_nxt.bresp = sps_pkg::RESP_SLVERR;
            endcase
         end
      end
      if (st_r.bv && s_axi_bready) begin
         st_nxt.bv = 1'b0;
      end

      // Read channel: address taken on arready, data the cycle after the handshake
      if (s_axi_arvalid && !st_r.arr && !st_r.rv) begin
         st_nxt.arr = 1'b1;
      end
      if (st_r.arr) begin
         ridx = word_idx(s_axi_araddr);
         st_nxt.arr = 1'b0;
         st_nxt.rv = 1'b1;
         st_nxt.rresp = sps_pkg::RESP_OKAY;
         st_nxt.rdata = '0;
         case (ridx)
            sps_pkg::IDX_SEL_A: st_nxt.rdata[8:0] = st_r.sel_a;
            sps_pkg::IDX_SEL_B: st_nxt.rdata[8:0] = st_r.sel_b;
            sps_pkg::IDX_SEL_C: st_nxt.rdata[8:0] = st_r.sel_c;
            sps_pkg::IDX_SEL_D: st_nxt.rdata[8:0] = st_r.sel_d;
            sps_pkg::IDX_MASK: st_nxt.rdata[8:0] = st_r.mask;
            sps_pkg::IDX_PEND: st_nxt.rdata[3:0] = st_r.pend;
            // Status shows masked flags too
            sps_pkg::IDX_STAT: st_nxt.rdata[4:0] = {rx_unlock, st_r.corrupt_flag,
               st_r.unusable_flag, st_r.burst_flag, st_r.nonaudio_flag};
            default: st_nxt.rresp = sps_pkg::RESP_SLVERR;
         endcase
      end else if (st_r.rv && s_axi_rready) begin
         st_nxt.rv = 1'b0;
      end

      // Sub-frame stage 1: flags and substitution decision
      st_nxt.s1_v = rx_valid;
      if (rx_valid) begin
         st_nxt.corrupt_flag = rx_corrupt;
         st_nxt.unusable_flag = rx_vbit;
         st_nxt.nonaudio_flag = rx_nonaudio;
         st_nxt.shreg = {st_r.shreg[94:0], rx_data[WIDTH-1]};
         st_nxt.burst_flag = ({st_r.shreg[94:0], rx_data[WIDTH-1]} == sps_pkg::SYNC_CODE)
            ? 1'b1 : (st_r.burst_flag && !rx_nonaudio ? st_r.burst_flag : 1'b0);
         // Masked flag substitutes; pass bit exempts unusable only
         unuse_sub = rx_vbit && st_r.mask[sps_pkg::MASK_UNUSABLE]
            && !st_r.sel_b[sps_pkg::FLAG_BIT];
         corr_sub = rx_corrupt && st_r.mask[sps_pkg::MASK_CORRUPT];
         st_nxt.s1_aud_sub = unuse_sub || corr_sub;
         st_nxt.s1_tx_sub = unuse_sub;
         st_nxt.s1_data = rx_data;
         st_nxt.s1_chan = rx_chan;
         // Unmasked set flags latch for the interrupt
         ev[0] = rx_vbit && !st_r.mask[sps_pkg::MASK_UNUSABLE];
         ev[1] = rx_corrupt && !st_r.mask[sps_pkg::MASK_CORRUPT];
      end
      // Non-PCM change events, masking hides only the interrupt
      ev[2] = (st_nxt.nonaudio_flag != st_r.nonaudio_flag) && !st_r.mask[sps_pkg::MASK_NONAUDIO];
      ev[3] = (st_nxt.burst_flag != st_r.burst_flag) && !st_r.mask[sps_pkg::MASK_BURST];
      // Set wins over a clear in the same cycle
      st_nxt.pend = st_nxt.pend | ev;

      // Stage 2: output with zero or last good fill
      st_nxt.aud_v = st_r.s1_v;
      st_nxt.tx_v = st_r.s1_v;
      if (st_r.s1_v) begin
         st_nxt.aud_c = st_r.s1_chan;
         st_nxt.tx_c = st_r.s1_chan;
         st_nxt.aud_d = !st_r.s1_aud_sub ? st_r.s1_data
            : (st_r.sel_a[sps_pkg::FLAG_BIT] ? '0 : hold_word);
         st_nxt.tx_d = !st_r.s1_tx_sub ? st_r.s1_data
            : (st_r.sel_a[sps_pkg::FLAG_BIT] ? '0 : hold_word);
      end

      // Mute from the live flags regardless of mask
      st_nxt.mute = first_converter_from_rx && (st_r.nonaudio_flag || st_r.burst_flag);
      st_nxt.irq_b = ~|st_r.pend;

      // Status pins
      sig = {rx_emph, rx_copy_low, st_r.nonaudio_flag | st_r.burst_flag, rx_zero,
             st_r.unusable_flag, rx_chan_stat_updated, rx_unlock, rx_blk_start, rx_valid,
             rx_pbit, rx_cbit, rx_ubit, rx_vbit};
      for (int i = 0; i < 7; i++) begin
         code = pin_sel_flat[i*4 +: 4];
         st_nxt.pin_o[i] = pick_src(code, st_r.irq_b, sig);
         st_nxt.pin_oe[i] = !((i >= 2) && (i <= 4) && (code >= sps_pkg::SRC_IN_CMOS));
      end
      for (int j = 0; j < 3; j++) begin
         code = pin_sel_flat[(j+2)*4 +: 4];
         st_nxt.in_cmos[j] = (code == sps_pkg::SRC_IN_CMOS) && pin_clean_r[j+2];
         st_nxt.in_cmp[j] = (code == sps_pkg::SRC_IN_CMP) && pin_clean_r[j+2];
      end
   end

   // Single state register
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
         st_r.sel_a <= sps_pkg::RST_SEL_A;
         st_r.sel_b <= sps_pkg::RST_SEL_B;
         st_r.sel_c <= sps_pkg::RST_SEL_C;
         st_r.sel_d <= sps_pkg::RST_SEL_D;
         st_r.mask <= sps_pkg::RST_MASK;
         st_r.irq_b <= 1'b1;
         st_r.pin_oe <= 7'h7f;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign s_axi_awready = st_r.awr;
   assign s_axi_wready = st_r.wr;
   assign s_axi_bvalid = st_r.bv;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = st_r.arr;
   assign s_axi_rvalid = st_r.rv;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign aud_valid = st_r.aud_v;
   assign aud_data = st_r.aud_d;
   assign aud_chan = st_r.aud_c;
   assign tx_valid = st_r.tx_v;
   assign tx_data = st_r.tx_d;
   assign tx_chan = st_r.tx_c;
   assign first_converter_mute = st_r.mute;
   assign int_b = st_r.irq_b;
   assign status_output_pin = st_r.pin_o;
   assign status_output_pin_oe = st_r.pin_oe;
   assign pin_rx_cmos = st_r.in_cmos;
   assign pin_rx_cmp = st_r.in_cmp;

   // Clean sample passes untouched two cycles later
   a_clean_pass: assert property (@(posedge core_clk) disable iff (!rst_b)
      rx_valid && !rx_vbit && !rx_corrupt |-> ##2 aud_valid && aud_data == $past(rx_data, 2))
      else $error("clean sample altered");
   // Masked corrupt frame gives zeros when zero fill chosen
   a_zero_fill: assert property (@(posedge core_clk) disable iff (!rst_b)
      rx_valid && rx_corrupt && st_r.mask[3] && st_r.sel_a[8] && $stable(st_r.sel_a)
      |-> ##2 aud_data == '0) else $error("zero fill missing");
   // Corruption never touches transmitter data
   a_tx_corrupt: assert property (@(posedge core_clk) disable iff (!rst_b)
      rx_valid && rx_corrupt && !rx_vbit |-> ##2 tx_data == $past(rx_data, 2))
      else $error("tx altered by corruption");
   // Pass bit lets marked samples through
   a_pass_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
      rx_valid && rx_vbit && !rx_corrupt && st_r.sel_b[8] |-> ##2 aud_data == $past(rx_data, 2))
      else $error("flagged sample not passed");
   // Unmasked unusable flag brings interrupt low within three cycles
   a_irq_raise: assert property (@(posedge core_clk) disable iff (!rst_b)
      rx_valid && rx_vbit && !st_r.mask[1] |-> ##[1:3] !int_b) else $error("no interrupt");
   // With no pending bit set, the interrupt is high the next cycle
   a_irq_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
      st_r.pend == '0 |=> int_b) else $error("spurious interrupt");
   // Mute follows non-PCM when sourced from receiver
   a_mute: assert property (@(posedge core_clk) disable iff (!rst_b)
      first_converter_from_rx && st_r.nonaudio_flag |=> first_converter_mute)
      else $error("mute missing");
   // Input codes on the fourth pin release its driver
   a_pin_in: assert property (@(posedge core_clk) disable iff (!rst_b)
      st_r.sel_b[7:4] >= sps_pkg::SRC_IN_CMOS |=> !status_output_pin_oe[3])
      else $error("pin still driven");
endmodule

// File: test/sps_rx_model.sv
`timescale 1ns/1ps
// Receiver front end: one sub-frame pulse per send, churning lines between
module sps_rx_model #(
   parameter int WIDTH = 24
) (
   input wire logic core_clk,
   output logic rx_valid,
   output logic [WIDTH-1:0] rx_data,
   output logic rx_chan,
   output logic rx_corrupt,
   output logic rx_vbit,
   output logic rx_ubit,
   output logic rx_cbit,
   output logic rx_pbit
);
   logic busy = 1'b0;
   // Quiet start
   initial begin
      rx_valid = 1'b0;
      rx_data = '0;
      {rx_chan, rx_corrupt, rx_vbit, rx_ubit, rx_cbit, rx_pbit} = 6'h00;
   end
   // Churn off the sampling edge so it never races a send
   always @(negedge core_clk) begin
      if (!busy) begin
         rx_data <= ~rx_data;
         rx_corrupt <= ~rx_corrupt;
         rx_vbit <= ~rx_vbit;
      end
   end
   // One sub-frame held for exactly one sampling edge
   task automatic send(input logic [WIDTH-1:0] d, input logic ch, input logic c,
                       input logic v);
      busy = 1'b1;
      rx_valid <= 1'b1;
      rx_data <= d;
      rx_chan <= ch;
      rx_corrupt <= c;
      rx_vbit <= v;
      rx_ubit <= 1'($urandom);
      rx_cbit <= 1'($urandom);
      rx_pbit <= 1'($urandom);
      @(posedge core_clk);
      rx_valid <= 1'b0;
      busy = 1'b0;
   endtask
endmodule

// File: test/sps_err_pins_bench.sv
`timescale 1ns/1ps
module sps_err_pins_bench;
   localparam int W = 24;
   localparam int LIMIT = 20000;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb = '0, pe;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, rx_valid, rx_chan, rx_corrupt, rx_vbit, rx_ubit, rx_cbit, rx_pbit;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [W-1:0] rx_data, aud_data, tx_data, last [2];
   logic rx_nonaudio = 0, rx_blk_start = 0, rx_unlock = 0, rx_chan_stat_updated = 0, rx_zero = 0;
   logic rx_copy_low = 0, rx_emph = 0, first_converter_from_rx = 0;
   logic [6:0] pin_in = '0, status_output_pin, status_output_pin_oe;
   logic aud_valid, aud_chan, tx_valid, tx_chan, first_converter_mute, int_b;
   logic [2:0] pin_rx_cmos, pin_rx_cmp;
   logic msk1, msk3, fill, pass, c, d;
   logic [3:0] codes [8] = '{4'h0, 4'h6, 4'h7, 4'h8, 4'ha, 4'hb, 4'hc, 4'hd};
   logic [7:0] ix [5] = '{sps_pkg::IDX_SEL_A, sps_pkg::IDX_SEL_B, sps_pkg::IDX_SEL_C,
                          sps_pkg::IDX_SEL_D, sps_pkg::IDX_MASK};
   logic [8:0] rv [5] = '{sps_pkg::RST_SEL_A, sps_pkg::RST_SEL_B, sps_pkg::RST_SEL_C,
                          sps_pkg::RST_SEL_D, sps_pkg::RST_MASK};
   int num_errors = 0, checks = 0, cycles = 0;
   int unsigned rnd;

   sps_err_pins #(.WIDTH(W)) u_sps_err_pins (.*);
   sps_rx_model #(.WIDTH(W)) u_sps_rx_model (.*);

   // Clock and hang guard
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         num_errors++;
         end_sim();
      end
   end

   task end_sim;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Bus write: address and data offered together, each dropped when taken
   task wr(input logic [7:0] idx, input logic [31:0] dat, input logic [3:0] s);
      logic a_ok, w_ok;
      a_ok = 0;
      w_ok = 0;
      @(posedge core_clk);
      s_axi_awaddr <= {22'h0, idx, 2'b00};
      s_axi_wdata <= dat;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(a_ok && w_ok)) begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) begin
            a_ok = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid) @(posedge core_clk);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task rd(input logic [7:0] idx, output logic [31:0] dat);
      @(posedge core_clk);
      s_axi_araddr <= {22'h0, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      dat = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task settle;
      repeat (8) @(posedge core_clk);
      #1;
   endtask

   // One sub-frame with expected audio and transmitter words worked out here
   task frame(input logic [W-1:0] dat, input logic ch, input logic cr, input logic vb);
      logic ba, bt;
      logic [W-1:0] ea, et;
      int n;
      ba = (cr && msk3) || (vb && msk1 && !pass);
      bt = vb && msk1 && !pass;
      ea = ba ? (fill ? '0 : last[ch]) : dat;
      et = bt ? (fill ? '0 : last[ch]) : dat;
      if (!ba && !bt) last[ch] = dat;
      n = 0;
      @(posedge core_clk);
      u_sps_rx_model.send(dat, ch, cr, vb);
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (!aud_valid && n < 6);
      chk(aud_valid, 1);
      chk(32'(aud_data), 32'(ea));
      chk(aud_chan, ch);
      chk(tx_valid, 1);
      chk(tx_chan, ch);
      chk(32'(tx_data), 32'(et));
   endtask

   function logic lvl(input logic [3:0] cd);
      case (cd)
         sps_pkg::SRC_IRQ: return int_b;
         sps_pkg::SRC_BLK: return rx_blk_start;
         sps_pkg::SRC_UNLOCK: return rx_unlock;
         sps_pkg::SRC_CHAN_STAT_UPDATED: return rx_chan_stat_updated;
         sps_pkg::SRC_ZERO: return rx_zero;
         sps_pkg::SRC_NONPCM: return rx_nonaudio;
         sps_pkg::SRC_COPY: return rx_copy_low;
         default: return rx_emph;
      endcase
   endfunction

   // Main sequence
   initial begin
      rnd = $urandom(54);
      {msk1, msk3, fill, pass} = 4'h0;
      last[0] = '0;
      last[1] = '0;
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd(ix[i], v);
         chk(v[8:0], rv[i]);
      end
      rd(8'h2a, v);
      chk(rsp, sps_pkg::RESP_SLVERR);
      rnd = $urandom;
      wr(sps_pkg::IDX_SEL_C, rnd & 32'h1ff, 4'hf);
      wr(sps_pkg::IDX_SEL_C, ~rnd, 4'h4);
      chk(rsp, sps_pkg::RESP_OKAY);
      rd(sps_pkg::IDX_SEL_C, v);
      chk(v[8:0], rnd[8:0]);
      // Unmasked flags pass data and raise the interrupt for the host
      pe = 4'h3;
      frame(24'hc0ffee, 0, 1, 1);
      for (int i = 0; i < 6; i++) begin
         c = 1'($urandom);
         d = 1'($urandom);
         pe |= {2'b00, c, d};
         frame(24'($urandom), i[0], c, d);
      end
      rd(sps_pkg::IDX_PEND, v);
      chk(v[1:0], pe[1:0]);
      chk(int_b, 0);
      wr(sps_pkg::IDX_PEND, 32'h3, 4'hf);
      rd(sps_pkg::IDX_PEND, v);
      chk(v[1:0], 2'b00);
      chk(int_b, 1);
      // Masked flags with zero fill; transmitter ignores corruption
      wr(sps_pkg::IDX_MASK, 32'h00a, 4'hf);
      wr(sps_pkg::IDX_SEL_A, {23'h0, 1'b1, sps_pkg::RST_SEL_A[7:0]}, 4'hf);
      {msk1, msk3, fill} = 3'h7;
      frame(24'h5a5a5a, 0, 1, 0);
      rd(sps_pkg::IDX_STAT, v);
      chk(v[3], 1);
      frame(24'h123456, 1, 0, 1);
      rd(sps_pkg::IDX_STAT, v);
      chk(v[2], 1);
      rd(sps_pkg::IDX_PEND, v);
      chk(v[1:0], 2'b00);
      chk(int_b, 1);
      // Last good sample per channel
      wr(sps_pkg::IDX_SEL_A, {23'h0, sps_pkg::RST_SEL_A}, 4'hf);
      fill = 0;
      for (int i = 0; i < 12; i++) frame(24'($urandom), 1'($urandom), 0, i > 1 && 1'($urandom));
      // Pass bit lets invalid samples through but not corrupted ones
      wr(sps_pkg::IDX_SEL_B, {23'h0, 1'b1, sps_pkg::RST_SEL_B[7:0]}, 4'hf);
      pass = 1;
      frame(24'habcdef, 0, 0, 1);
      frame(24'h654321, 1, 1, 0);
      // Non-PCM mute, masked then unmasked change event
      wr(sps_pkg::IDX_MASK, 32'h03a, 4'hf);
      @(posedge core_clk);
      first_converter_from_rx <= 1'b1;
      rx_nonaudio <= 1'b1;
      // Channel-status level is latched with a sub-frame
      frame(24'h13579b, 0, 0, 0);
      chk(first_converter_mute, 1);
      rd(sps_pkg::IDX_PEND, v);
      chk(v[2], 0);
      rd(sps_pkg::IDX_STAT, v);
      chk(v[0], 1);
      wr(sps_pkg::IDX_MASK, 32'h00a, 4'hf);
      @(posedge core_clk);
      rx_nonaudio <= 1'b0;
      frame(24'h2468ac, 1, 0, 0);
      chk(first_converter_mute, 0);
      chk(int_b, 0);
      rd(sps_pkg::IDX_PEND, v);
      chk(v[2], 1);
      wr(sps_pkg::IDX_PEND, 32'hf, 4'hf);
      wr(sps_pkg::IDX_MASK, 32'h03a, 4'hf);
      @(posedge core_clk);
      first_converter_from_rx <= 1'b0;
      rx_nonaudio <= 1'b1;
      frame(24'h0f0f0f, 0, 0, 0);
      chk(first_converter_mute, 0);
      // Status pin sources on the seventh pin
      for (int i = 0; i < 8; i++) begin
         wr(sps_pkg::IDX_SEL_D, {28'h0, codes[i]}, 4'hf);
         @(posedge core_clk);
         {rx_blk_start, rx_unlock, rx_chan_stat_updated, rx_zero, rx_copy_low, rx_emph} <= 6'($urandom);
         rx_nonaudio <= 1'($urandom);
         frame(24'($urandom), 0, 0, 0);
         settle();
         chk(status_output_pin[6], lvl(codes[i]));
         chk(status_output_pin_oe[6], 1);
      end
      // Fourth pin turned into a receiver input, both kinds
      for (int i = 0; i < 2; i++) begin
         wr(sps_pkg::IDX_SEL_B, {23'h0, 1'b1, 3'b111, i[0], 4'h2}, 4'hf);
         @(posedge core_clk);
         pin_in <= 7'($urandom);
         settle();
         chk(status_output_pin_oe[3], 0);
         chk(i ? pin_rx_cmp[1] : pin_rx_cmos[1], pin_in[3]);
      end
      end_sim();
   end
endmodule
